// *** tsp_pkg.sv ***
package tsp_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int NUM_CB = 6;
	localparam int CNT_W  = 16;
	localparam int DIV_W  = 8;
	localparam int XFER_W = 32;
	localparam int ADDR_W = 8;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_DATA  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_COND  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_TIME  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_STAMP = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h14;
	// clock block n config at 8'h20 + 4*n
	localparam logic [2:0]        CB_PAGE   = 3'h1;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTL_EN_BIT    = 0;
	localparam int CTL_DIR_BIT   = 1;
	localparam int CTL_OD_BIT    = 2;
	localparam int CTL_ISTB_BIT  = 3;
	localparam int CTL_OSTB_BIT  = 4;
	localparam int CTL_SEL_LSB   = 5;
	localparam int CTL_CMODE_LSB = 8;
	localparam int CBC_SRC_BIT   = 0;
	localparam int CBC_DIV_LSB   = 1;
	localparam int ST_FULL_BIT   = 0;
	localparam int ST_ARMED_BIT  = 1;
	localparam int ST_BUSY_BIT   = 2;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [2:0]       RST_CB_SEL = 3'h0;
	localparam logic [DIV_W-1:0] RST_CB_DIV = 8'h00;

	typedef enum logic [1:0] {
		TSP_COND_OFF,
		TSP_COND_EQ,
		TSP_COND_NEQ
	} tsp_cond_t;

endpackage

// *** tsp_cb_if.sv ***
`timescale 1ns/1ps
interface tsp_cb_if;
	logic                     src_pin;
	logic [tsp_pkg::DIV_W-1:0] div;
	logic                     ext_lvl;
	logic                     tick;

	modport ctrl (output src_pin, output div, output ext_lvl, input tick);
	modport blk  (input src_pin, input div, input ext_lvl, output tick);
endinterface

// *** tsp_clk_blk.sv ***
`timescale 1ns/1ps
module tsp_clk_blk #(
	parameter bit IS_REF = 1'b0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// config and tick
	tsp_cb_if.blk    cb
);

	logic                      ext_prev_ff;
	logic [tsp_pkg::DIV_W-1:0] div_cnt_ff;
	logic                      tick_ff;
	logic                      src_ev;
	logic [tsp_pkg::DIV_W-1:0] div_lim;

	// ----------------------------------------
	// source select
	// ----------------------------------------
	// pin source edge
	assign src_ev  = IS_REF ? 1'b1 : (cb.src_pin ? (cb.ext_lvl & ~ext_prev_ff) : 1'b1);
	assign div_lim = IS_REF ? tsp_pkg::RST_CB_DIV : cb.div;

	always_ff @(posedge mclk)
	begin
		if (rst)
			ext_prev_ff <= 1'b0;
		else
			ext_prev_ff <= cb.ext_lvl;
	end

	// ----------------------------------------
	// divider
	// ----------------------------------------
	// divide source edges
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			div_cnt_ff <= tsp_pkg::RST_CB_DIV;
			tick_ff    <= 1'b0;
		end
		else if (src_ev && div_cnt_ff >= div_lim)
		begin
			div_cnt_ff <= tsp_pkg::RST_CB_DIV;
			tick_ff    <= 1'b1;
		end
		else
		begin
			div_cnt_ff <= src_ev ? div_cnt_ff + 1'b1 : div_cnt_ff;
			tick_ff    <= 1'b0;
		end
	end

	assign cb.tick = tick_ff;

	a_ref_always_ticks:
	assert property (@(posedge mclk) disable iff (rst)
		IS_REF && !$past(rst) |-> tick_ff)
	else $error("reference clock block missed a tick");

endmodule

// *** tsp_port.sv ***
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - port widths 1, 4, 8, 16, 32
// - one direction for all pins
// - drive, sample, optionally wait for condition
// - open drain: zero drives, one floats
// - every access completes in one cycle
// - shift register plus transfer register
// - 16-bit counter times each transfer
// - counter readable; defers transfer until count
// - counter captured as timestamp per transfer
// - conditions raise events, not interrupts
// - enabled link disables port pins
// - narrower enabled port beats wider port
// - unshared pins stay with wider port
// - transfers at nominal width, except a conditional capture takes one slice
// - six clock blocks, block 0 reference
// - clock block sourced from 1-bit pin
// - pin clock source optionally divided
// - input strobe qualifies, output strobe accompanies
// - reset attaches port to block 0
module tsp_port #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic                       mclk,
	input  wire logic                       rst,
	// register port
	input  wire logic [tsp_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [tsp_pkg::XFER_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [tsp_pkg::XFER_W-1:0] reg_rdata,
	// pins
	input  wire logic [W-1:0]               pin_in,
	output logic      [W-1:0]               pin_out,
	output logic      [W-1:0]               pin_oe_n,
	input  wire logic                       input_strobe,
	output logic                            output_strobe,
	// pin sharing
	input  wire logic                       link_active,
	input  wire logic [W-1:0]               narrow_claim,
	// clock block sources
	input  wire logic [tsp_pkg::NUM_CB-2:0] cb_src_pin,
	// event to tile
	output logic                            port_event
);

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	// legal width, whole shifts
	localparam int N_SH = tsp_pkg::XFER_W / W;
	localparam int SH_W = $clog2(N_SH + 1);
	localparam logic [SH_W-1:0] SH_LAST = SH_W'(N_SH - 1);

	logic                          en_ff;
	logic                          dir_ff;
	logic                          od_ff;
	logic                          istb_en_ff;
	logic                          ostb_en_ff;
	logic [2:0]                    cb_sel_ff;
	tsp_pkg::tsp_cond_t            cond_mode_ff;
	logic [W-1:0]                  cond_val_ff;
	logic [tsp_pkg::CNT_W-1:0]     time_val_ff;
	logic                          armed_ff;
	logic [tsp_pkg::CNT_W-1:0]     cnt_ff;
	logic [tsp_pkg::CNT_W-1:0]     stamp_ff;
	logic [tsp_pkg::XFER_W-1:0]    shift_ff;
	logic [tsp_pkg::XFER_W-1:0]    xfer_ff;
	logic                          full_ff;
	logic [SH_W-1:0]               sh_cnt_ff;
	logic [W-1:0]                  drv_ff;
	logic                          ostb_pend_ff;
	logic [tsp_pkg::XFER_W-1:0]    rdata_ff;
	logic [W-1:0]                  pin_out_ff;
	logic [W-1:0]                  pin_oe_n_ff;
	logic                          output_strobe_ff;
	logic                          port_event_ff;
	logic [tsp_pkg::NUM_CB-1:0]    cb_src_ff;
	logic [tsp_pkg::DIV_W-1:0]     cb_div_ff [tsp_pkg::NUM_CB];
	logic [tsp_pkg::NUM_CB-1:0]    cb_tick;
	logic [7:0]                    cb_tick_all;

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	logic       wr_ctrl;
	logic       wr_data;
	logic       wr_cond;
	logic       wr_time;
	logic       rd_data;
	logic       cb_hit;
	logic [2:0] cb_idx;
	logic       cb_ok;

	assign wr_ctrl = reg_wr && reg_addr == tsp_pkg::OFF_CTRL;
	assign wr_data = reg_wr && reg_addr == tsp_pkg::OFF_DATA;
	assign wr_cond = reg_wr && reg_addr == tsp_pkg::OFF_COND;
	assign wr_time = reg_wr && reg_addr == tsp_pkg::OFF_TIME;
	assign rd_data = reg_rd && reg_addr == tsp_pkg::OFF_DATA;
	assign cb_hit  = reg_addr[7:5] == tsp_pkg::CB_PAGE && reg_addr[1:0] == 2'h0;
	assign cb_idx  = reg_addr[4:2];
	assign cb_ok   = cb_hit && cb_idx < 3'(tsp_pkg::NUM_CB);

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	logic [2:0] wr_sel;
	assign wr_sel = reg_wdata[tsp_pkg::CTL_SEL_LSB +: 3];

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			en_ff        <= 1'b0;
			dir_ff       <= 1'b0;
			od_ff        <= 1'b0;
			istb_en_ff   <= 1'b0;
			ostb_en_ff   <= 1'b0;
			cb_sel_ff    <= tsp_pkg::RST_CB_SEL;
			cond_mode_ff <= tsp_pkg::TSP_COND_OFF;
		end
		else if (wr_ctrl)
		begin
			en_ff        <= reg_wdata[tsp_pkg::CTL_EN_BIT];
			dir_ff       <= reg_wdata[tsp_pkg::CTL_DIR_BIT];
			od_ff        <= reg_wdata[tsp_pkg::CTL_OD_BIT];
			istb_en_ff   <= reg_wdata[tsp_pkg::CTL_ISTB_BIT];
			ostb_en_ff   <= reg_wdata[tsp_pkg::CTL_OSTB_BIT];
			// out-of-range selects are dropped, keeping the old block
			if (wr_sel < 3'(tsp_pkg::NUM_CB))
				cb_sel_ff <= wr_sel;
			cond_mode_ff <= tsp_pkg::tsp_cond_t'(reg_wdata[tsp_pkg::CTL_CMODE_LSB +: 2]);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cond_val_ff <= '0;
			time_val_ff <= '0;
		end
		else
		begin
			if (wr_cond)
				cond_val_ff <= reg_wdata[W-1:0];
			if (wr_time)
				time_val_ff <= reg_wdata[tsp_pkg::CNT_W-1:0];
		end
	end

	// ----------------------------------------
	// clock blocks
	// ----------------------------------------
	// six blocks, first is reference
	for (genvar g = 0; g < tsp_pkg::NUM_CB; g++)
	begin : g_cb
		tsp_cb_if cb_if ();

		always_ff @(posedge mclk)
		begin
			if (rst)
			begin
				cb_src_ff[g] <= 1'b0;
				cb_div_ff[g] <= tsp_pkg::RST_CB_DIV;
			end
			else if (reg_wr && cb_ok && cb_idx == 3'(g) && g != 0)
			begin
				cb_src_ff[g] <= reg_wdata[tsp_pkg::CBC_SRC_BIT];
				cb_div_ff[g] <= reg_wdata[tsp_pkg::CBC_DIV_LSB +: tsp_pkg::DIV_W];
			end
		end

		assign cb_if.src_pin = cb_src_ff[g];
		assign cb_if.div     = cb_div_ff[g];
		if (g == 0)
		begin : g_ref
			assign cb_if.ext_lvl = 1'b0;
		end
		else
		begin : g_pin
			assign cb_if.ext_lvl = cb_src_pin[g-1];
		end
		assign cb_tick[g] = cb_if.tick;

		tsp_clk_blk #(
			.IS_REF (g == 0)
		) u_blk (
			.mclk (mclk),
			.rst  (rst),
			.cb   (cb_if.blk)
		);
	end

	assign cb_tick_all = 8'(cb_tick);

	// ----------------------------------------
	// port timing
	// ----------------------------------------
	logic port_tick;
	logic go;
	assign port_tick = cb_tick_all[cb_sel_ff];
	assign go = port_tick && en_ff && (!armed_ff || cnt_ff == time_val_ff);

	always_ff @(posedge mclk)
	begin
		if (rst)
			cnt_ff <= '0;
		else if (port_tick && en_ff)
			cnt_ff <= cnt_ff + 1'b1;
	end

	a_counter_step:
	assert property (@(posedge mclk) disable iff (rst)
		port_tick && en_ff |=> cnt_ff == $past(cnt_ff) + 16'h0001)
	else $error("port counter did not step on tick");

	// ----------------------------------------
	// sampling
	// ----------------------------------------
	logic [W-1:0]              pin_off;
	logic [W-1:0]              samp;
	logic                      in_ok;
	logic                      cond_hit;
	logic                      in_step;
	logic                      in_cap;
	logic                      out_load;
	logic                      out_shift;
	logic [tsp_pkg::XFER_W+W-1:0] cat_in;

	assign pin_off = {W{link_active}} | narrow_claim;
	assign samp    = pin_in & ~pin_off;
	assign in_ok   = !dir_ff && (!istb_en_ff || input_strobe);

	always_comb
	begin
		unique case (cond_mode_ff)
			tsp_pkg::TSP_COND_EQ:  cond_hit = samp == cond_val_ff;
			tsp_pkg::TSP_COND_NEQ: cond_hit = samp != cond_val_ff;
			default:               cond_hit = 1'b0;
		endcase
	end

	assign in_step   = go && in_ok && cond_mode_ff == tsp_pkg::TSP_COND_OFF;
	assign in_cap    = (in_step && sh_cnt_ff == SH_LAST) || (go && in_ok && cond_hit && !full_ff);
	assign out_load  = go && dir_ff && sh_cnt_ff == '0 && full_ff;
	assign out_shift = go && dir_ff && sh_cnt_ff != '0;
	assign cat_in    = {samp, shift_ff} >> W;

	// ----------------------------------------
	// serializer and transfer register
	// ----------------------------------------
	// shift then transfer register
	always_ff @(posedge mclk)
	begin
		if (rst || wr_ctrl)
		begin
			shift_ff  <= '0;
			sh_cnt_ff <= '0;
		end
		else if (in_step)
		begin
			shift_ff  <= cat_in[tsp_pkg::XFER_W-1:0];
			sh_cnt_ff <= sh_cnt_ff == SH_LAST ? '0 : sh_cnt_ff + 1'b1;
		end
		else if (out_load)
		begin
			shift_ff  <= xfer_ff >> W;
			sh_cnt_ff <= SH_LAST;
		end
		else if (out_shift)
		begin
			shift_ff  <= shift_ff >> W;
			sh_cnt_ff <= sh_cnt_ff - 1'b1;
		end
	end

	// a new shifted input word overwrites an unread one; conditional captures wait until it is read
	always_ff @(posedge mclk)
	begin
		if (rst)
			xfer_ff <= '0;
		else if (in_cap && cond_mode_ff == tsp_pkg::TSP_COND_OFF)
			xfer_ff <= cat_in[tsp_pkg::XFER_W-1:0];
		else if (in_cap)
			xfer_ff <= tsp_pkg::XFER_W'(samp);
		else if (wr_data && dir_ff)
			xfer_ff <= reg_wdata;
	end

	// set beats clear so a word landing on a read is not lost
	always_ff @(posedge mclk)
	begin
		if (rst)
			full_ff <= 1'b0;
		else
			full_ff <= in_cap || (wr_data && dir_ff) ||
				(full_ff && !(rd_data && !dir_ff) && !out_load);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			stamp_ff <= '0;
		else if (in_cap || out_load)
			stamp_ff <= cnt_ff;
	end

	a_stamp_capture:
	assert property (@(posedge mclk) disable iff (rst)
		in_cap || out_load |=> stamp_ff == $past(cnt_ff))
	else $error("timestamp not taken from counter");

	always_ff @(posedge mclk)
	begin
		if (rst)
			armed_ff <= 1'b0;
		else
			armed_ff <= wr_time || (armed_ff && !go);
	end

	a_timed_hold:
	assert property (@(posedge mclk) disable iff (rst)
		armed_ff && cnt_ff != time_val_ff && !wr_ctrl |=> $stable(sh_cnt_ff))
	else $error("transfer ran before programmed count");

	// ----------------------------------------
	// events and output strobe
	// ----------------------------------------
	// event pulse to tile
	always_ff @(posedge mclk)
	begin
		if (rst)
			port_event_ff <= 1'b0;
		else
			port_event_ff <= in_cap || out_load;
	end

	a_event_on_xfer:
	assert property (@(posedge mclk) disable iff (rst)
		in_cap |=> port_event_ff && full_ff)
	else $error("capture raised no event");

	a_cond_match:
	assert property (@(posedge mclk) disable iff (rst)
		go && in_ok && cond_hit && !full_ff |=> xfer_ff == 32'($past(samp)))
	else $error("conditional capture took wrong value");

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			drv_ff       <= '0;
			ostb_pend_ff <= 1'b0;
		end
		else
		begin
			if (out_load)
				drv_ff <= xfer_ff[W-1:0];
			else if (out_shift)
				drv_ff <= shift_ff[W-1:0];
			ostb_pend_ff <= out_load || out_shift;
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	// drive high or low; open drain drives low or floats
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pin_out_ff       <= '0;
			pin_oe_n_ff      <= '1;
			output_strobe_ff <= 1'b0;
		end
		else
		begin
			pin_out_ff       <= od_ff ? '0 : drv_ff;
			pin_oe_n_ff      <= {W{!(dir_ff && en_ff)}} | pin_off | ({W{od_ff}} & drv_ff);
			output_strobe_ff <= ostb_pend_ff && ostb_en_ff;
		end
	end

	a_od_never_high:
	assert property (@(posedge mclk) disable iff (rst)
		$past(od_ff) && !$past(rst) |-> (pin_out_ff & ~pin_oe_n_ff) == '0)
	else $error("open drain pin driven high");

	a_link_pins_off:
	assert property (@(posedge mclk) disable iff (rst)
		link_active ##1 1'b1 |-> &pin_oe_n_ff)
	else $error("pin driven while link enabled");

	a_input_no_drive:
	assert property (@(posedge mclk) disable iff (rst)
		!dir_ff ##1 1'b1 |-> &pin_oe_n_ff)
	else $error("input port drove a pin");

	a_reset_block0:
	assert property (@(posedge mclk) disable iff (rst)
		$past(rst) |-> cb_sel_ff == 3'h0)
	else $error("port not on block 0 after reset");

	// ----------------------------------------
	// read port
	// ----------------------------------------
	// counter readable any time
	always_ff @(posedge mclk)
	begin
		if (rst || !reg_rd)
			rdata_ff <= '0;
		else if (reg_addr == tsp_pkg::OFF_CTRL)
			rdata_ff <= 32'({cond_mode_ff, cb_sel_ff, ostb_en_ff, istb_en_ff,
				od_ff, dir_ff, en_ff});
		else if (reg_addr == tsp_pkg::OFF_DATA)
			rdata_ff <= xfer_ff;
		else if (reg_addr == tsp_pkg::OFF_COND)
			rdata_ff <= 32'(cond_val_ff);
		else if (reg_addr == tsp_pkg::OFF_TIME)
			rdata_ff <= 32'(cnt_ff);
		else if (reg_addr == tsp_pkg::OFF_STAMP)
			rdata_ff <= 32'(stamp_ff);
		else if (reg_addr == tsp_pkg::OFF_STAT)
			rdata_ff <= 32'({sh_cnt_ff != '0, armed_ff, full_ff});
		else if (cb_ok)
			rdata_ff <= 32'({cb_div_ff[cb_idx], cb_src_ff[cb_idx]});
		else
			rdata_ff <= 32'h0000_0000;
	end

	a_read_latency:
	assert property (@(posedge mclk) disable iff (rst)
		reg_rd && reg_addr == tsp_pkg::OFF_TIME |=> reg_rdata == 32'($past(cnt_ff)))
	else $error("counter read not answered next cycle");

	assign reg_rdata     = rdata_ff;
	assign pin_out       = pin_out_ff;
	assign pin_oe_n      = pin_oe_n_ff;
	assign output_strobe = output_strobe_ff;
	assign port_event    = port_event_ff;

endmodule

// *** tsp_pins_model.sv ***
`timescale 1ns/1ps
module tsp_pins_model #(
	parameter int W = 8
) (
	// clock
	input  wire logic         mclk,
	// device pins
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe_n,
	output logic      [W-1:0] pin_in,
	output logic              input_strobe,
	output logic      [4:0]   cb_src_pin
);
	logic         drv_en = 1'b0;
	logic [W-1:0] drv    = '0;

	initial
	begin
		input_strobe = 1'b0;
		cb_src_pin   = 5'h00;
	end

	// ----------------------------------------
	// pin level
	// ----------------------------------------
	// external pull-up wins when nobody drives
	always_comb
		for (int i = 0; i < W; i++)
			pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (drv_en ? drv[i] : 1'b1);

	// ----------------------------------------
	// stimulus tasks
	// ----------------------------------------
	// strobe qualifies data
	task automatic put_slice(input logic [W-1:0] v);
		drv_en <= 1'b1;
		drv    <= ~v;
		@(posedge mclk);
		drv          <= v;
		input_strobe <= 1'b1;
		@(posedge mclk);
		input_strobe <= 1'b0;
		@(posedge mclk);
		drv <= ~v;
		@(posedge mclk);
	endtask

	task automatic set_level(input logic [W-1:0] v);
		drv_en <= 1'b1;
		drv    <= v;
	endtask

	task automatic release_pins();
		drv_en <= 1'b0;
	endtask

	// clock pin stands still between bursts
	task automatic src_pulses(input int n);
		repeat (n)
		begin
			@(posedge mclk);
			cb_src_pin[0] <= 1'b1;
			repeat (2) @(posedge mclk);
			cb_src_pin[0] <= 1'b0;
			@(posedge mclk);
		end
	endtask
endmodule

// *** timed_serdes_io_port_tb.sv ***
`timescale 1ns/1ps
module timed_serdes_io_port_tb;
	localparam int          W   = 8;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	logic                       mclk         = 1'b0;
	logic                       rst          = 1'b1;
	logic [tsp_pkg::ADDR_W-1:0] reg_addr     = '0;
	logic [31:0]                reg_wdata    = '0;
	logic                       reg_wr       = 1'b0;
	logic                       reg_rd       = 1'b0;
	logic [31:0]                reg_rdata;
	logic [W-1:0]               pin_in;
	logic [W-1:0]               pin_out;
	logic [W-1:0]               pin_oe_n;
	logic [W-1:0]               narrow_claim = '0;
	logic                       link_active  = 1'b0;
	logic                       input_strobe;
	logic                       output_strobe;
	logic                       port_event;
	logic [4:0]                 cb_src_pin;
	logic                       rd_seen      = 1'b0;
	logic [31:0]                rq_e[$];
	logic [31:0]                rq_m[$];
	logic [W-1:0]               oq_out[$];
	logic [W-1:0]               oq_oe[$];
	logic [31:0]                word;
	logic [W-1:0]               cl;
	int                         n_fail       = 0;
	int                         n_tests      = 0;
	int                         n_evt        = 0;
	int                         n_stb        = 0;
	int                         cyc          = 0;
	int                         e0;

	initial
		forever #12.5 mclk = ~mclk;

	tsp_port #(.W(W)) dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.input_strobe(input_strobe), .output_strobe(output_strobe),
		.link_active(link_active), .narrow_claim(narrow_claim),
		.cb_src_pin(cb_src_pin), .port_event(port_event));

	tsp_pins_model #(.W(W)) pin_model_u (.mclk(mclk), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pin_in(pin_in), .input_strobe(input_strobe),
		.cb_src_pin(cb_src_pin));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		if (oq_oe.size() != 0 || rq_e.size() != 0)
			n_fail++;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		rq_e.push_back(e & m);
		rq_m.push_back(m);
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask

	function automatic logic [31:0] ctl(input logic [4:0] f, input logic [2:0] s,
		input logic [1:0] cm);
		return {22'h00_0000, cm, s, f};
	endfunction

	task automatic push_word(input logic [31:0] w, input logic od, input logic [W-1:0] c);
		for (int i = 0; i < 4; i++)
		begin
			oq_out.push_back(od ? 8'h00 : w[8*i +: 8]);
			oq_oe.push_back((od ? w[8*i +: 8] : 8'h00) | c);
		end
	endtask

	// ----------------------------------------
	// monitors
	// ----------------------------------------
	// read data stands only in the cycle after the strobe
	always @(posedge mclk)
	begin
		if (port_event === 1'b1)
			n_evt++;
		if (rd_seen)
			chk(reg_rdata & rq_m.pop_front(), rq_e.pop_front());
		if (output_strobe === 1'b1)
		begin
			n_stb++;
			if (oq_oe.size() > 0)
			begin
				chk(pin_oe_n, oq_oe[0]);
				chk(pin_out & ~oq_oe[0], oq_out.pop_front() & ~oq_oe[0]);
				void'(oq_oe.pop_front());
			end
		end
		rd_seen <= reg_rd;
	end

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_fail++;
			end_of_test();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'he469_cd0b));
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk(pin_oe_n, 8'hff);
		rd(tsp_pkg::OFF_CTRL, 32'h0000_0000, ALL);
		rd(tsp_pkg::OFF_TIME, 32'h0000_0000, ALL);
		rd(8'h40, 32'h0000_0000, ALL);
		$display("test reset done");

		pin_model_u.set_level(8'h5a);
		// arm while disabled so no slice is shifted before the deadline
		wr(tsp_pkg::OFF_TIME, 32'h0000_0100);
		wr(tsp_pkg::OFF_CTRL, ctl(5'h01, 3'h0, 2'h0));
		e0 = n_evt;
		repeat (200) @(posedge mclk);
		chk(n_evt - e0, 0);
		rd(tsp_pkg::OFF_STAT, 32'h0000_0002, 32'h0000_0002);
		for (int i = 0; i < 300 && n_evt == e0; i++)
			@(posedge mclk);
		chk(n_evt - e0, 1);
		rd(tsp_pkg::OFF_STAMP, 32'h0000_0103, 32'h0000_ffff);
		rd(tsp_pkg::OFF_DATA, 32'h5a5a_5a5a, ALL);
		$display("test deferred done");

		cl = W'($urandom);
		word = $urandom;
		narrow_claim <= cl;
		wr(tsp_pkg::OFF_CTRL, ctl(5'h09, 3'h0, 2'h0));
		// let an event from the free-running mode drain first
		repeat (2) @(posedge mclk);
		e0 = n_evt;
		for (int i = 0; i < 4; i++)
			pin_model_u.put_slice(word[8*i +: 8]);
		repeat (4) @(posedge mclk);
		chk(n_evt - e0, 1);
		rd(tsp_pkg::OFF_DATA, word & ~{4{cl}}, ALL);
		rd(tsp_pkg::OFF_STAT, 32'h0000_0000, 32'h0000_0001);
		narrow_claim <= '0;
		$display("test strobed input done");

		for (int m = 1; m < 3; m++)
		begin
			word = $urandom;
			cl = (m == 1) ? word[7:0] : ~word[7:0];
			pin_model_u.set_level(~cl);
			wr(tsp_pkg::OFF_COND, word);
			wr(tsp_pkg::OFF_CTRL, ctl(5'h01, 3'h0, m[1:0]));
			e0 = n_evt;
			repeat (10) @(posedge mclk);
			chk(n_evt - e0, 0);
			pin_model_u.set_level(cl);
			repeat (10) @(posedge mclk);
			chk(n_evt - e0, 1);
			rd(tsp_pkg::OFF_DATA, {24'h00_0000, cl}, ALL);
			// a match still standing recaptures; disable, then drain full
			wr(tsp_pkg::OFF_CTRL, 32'h0000_0000);
			rd(tsp_pkg::OFF_DATA, {24'h00_0000, cl}, ALL);
		end
		$display("test conditional done");

		pin_model_u.release_pins();
		wr(8'h20, 32'h0000_0003);
		rd(8'h20, 32'h0000_0000, ALL);
		for (int c = 0; c < 3; c++)
		begin
			cl = (c == 2) ? W'($urandom) : '0;
			narrow_claim <= cl;
			word = $urandom;
			wr(tsp_pkg::OFF_CTRL, ctl((c == 1) ? 5'h17 : 5'h13, 3'h0, 2'h0));
			push_word(word, c == 1, cl);
			wr(tsp_pkg::OFF_DATA, word);
			repeat (12) @(posedge mclk);
		end
		link_active <= 1'b1;
		wr(tsp_pkg::OFF_DATA, $urandom);
		repeat (12) @(posedge mclk);
		chk(pin_oe_n, 8'hff);
		link_active  <= 1'b0;
		narrow_claim <= '0;
		$display("test output done");

		wr(8'h24, 32'h0000_0003);
		rd(8'h24, 32'h0000_0003, ALL);
		wr(tsp_pkg::OFF_CTRL, ctl(5'h13, 3'h1, 2'h0));
		wr(tsp_pkg::OFF_CTRL, ctl(5'h13, 3'h7, 2'h0));
		rd(tsp_pkg::OFF_CTRL, 32'h0000_0020, 32'h0000_00e0);
		word = $urandom;
		push_word(word, 1'b0, '0);
		wr(tsp_pkg::OFF_DATA, word);
		e0 = n_stb;
		pin_model_u.src_pulses(4);
		repeat (6) @(posedge mclk);
		chk(n_stb - e0, 2);
		pin_model_u.src_pulses(4);
		repeat (6) @(posedge mclk);
		chk(n_stb - e0, 4);
		$display("test clock block done");
		end_of_test();
	end
endmodule
